// File: verilog/eeprom_pkg.sv
// Constants, types and shared decode for the SPI EEPROM core
package eeprom_pkg;
  // Opcodes
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_CLEAR_LATCH = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  // Status register layout
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_LATCH_BIT = 1;
  localparam int STAT_BP_LSB = 2;
  localparam int STAT_BP_MSB = 3;
  localparam int STAT_RSV_LSB = 4;
  localparam int STAT_RSV_MSB = 6;
  localparam int STAT_GUARD_BIT = 7;
  localparam logic [2:0] NV_FACTORY = 3'h0;
  localparam logic [2:0] RSV_BUSY = 3'h7;
  localparam logic [2:0] RSV_IDLE = 3'h0;
  // Array geometry
  localparam int ADDR_W = 18;
  localparam logic [17:0] QUARTER_BASE = 18'h30000;
  localparam logic [17:0] HALF_BASE = 18'h20000;
  localparam int WORDS = 65536;
  localparam int ROW_WORDS = 64;
  localparam int WORD_W = 38;
  localparam int ECC_W = 6;
  localparam logic [1:0] ADDR_LAST_BYTE = 2'h2;
  // Timing: self-timed write, longest time rounded down
  localparam int CLK_HZ = 10_000_000;
  localparam int WRITE_TIME_US = 10_000;
  localparam int WRITE_CYCLES = WRITE_TIME_US * (CLK_HZ / 1_000_000);
  localparam int BUSY_CNT_W = 17;
  typedef logic [BUSY_CNT_W-1:0] busy_cnt_t;

  typedef enum logic [5:0] {
    ST_OPCODE = 6'h01,
    ST_ADDR = 6'h02,
    ST_DATA = 6'h04,
    ST_READ = 6'h08,
    ST_STATUS = 6'h10,
    ST_IGNORE = 6'h20
  } spi_state_t;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
  } pins_t;

  localparam pins_t PINS_IDLE = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b1};

  // Block guard decode: high when the address is read-only
  function automatic logic array_locked(input logic [1:0] bp, input logic [17:0] a);
    case (bp)
      2'h1: array_locked = (a >= QUARTER_BASE);
      2'h2: array_locked = (a >= HALF_BASE);
      2'h3: array_locked = 1'b1;
      default: array_locked = 1'b0;
    endcase
  endfunction
endpackage

// File: verilog/ecc_hamming.sv
// Single-error-correcting code over one 32-bit array word with 6 check bits
`timescale 1ns/1ps
module ecc_hamming (
  // Encode side
  input wire logic [31:0] wr_data_i,
  output logic [5:0] wr_check_o,
  // Correct side: stored word is {check, data}
  input wire logic [37:0] rd_word_i,
  output logic [31:0] rd_data_o
);
  // Data bits occupy codeword positions that are not powers of two
  function automatic logic [37:0] place(input logic [31:0] d);
    int k;
    place = '0;
    k = 0;
    for (int p = 1; p <= 38; p++) begin
      if ((p & (p - 1)) != 0) begin
        place[p-1] = d[k];
        k++;
      end
    end
  endfunction

  function automatic logic [31:0] extract(input logic [37:0] cw);
    int k;
    extract = '0;
    k = 0;
    for (int p = 1; p <= 38; p++) begin
      if ((p & (p - 1)) != 0) begin
        extract[k] = cw[p-1];
        k++;
      end
    end
  endfunction

  function automatic logic [5:0] parity(input logic [37:0] cw);
    parity = '0;
    for (int i = 0; i < 6; i++) begin
      for (int p = 1; p <= 38; p++) begin
        if (p[i]) parity[i] = parity[i] ^ cw[p-1];
      end
    end
  endfunction

  logic [37:0] cw;
  logic [5:0] syndrome;

  assign wr_check_o = parity(place(wr_data_i));

  always_comb begin
    cw = place(rd_word_i[31:0]);
    for (int i = 0; i < 6; i++) begin
      cw[(1 << i) - 1] = rd_word_i[32 + i];
    end
    syndrome = parity(cw);
    if (syndrome != 6'h00 && syndrome <= 6'h26) begin
      cw[syndrome - 6'h01] = ~cw[syndrome - 6'h01];
    end
    rd_data_o = extract(cw);
  end
endmodule // ecc_hamming

// File: verilog/spi_eeprom_core.sv
// SPI EEPROM command, protection, array and self-timed write logic
// Notes on behaviour
// - Status write changes only bits 7,3,2
// - Guard bits kept non-volatile across power loss
// - While busy, only status read is obeyed
// - Write cycle end clears write enable latch
// - Block guard decodes none/quarter/half/all
// - Guard enable off: latch alone rules status
// - Latch clear refuses all status, array writes
// - Pin low, guard on: status locked
// - Pin high or guard off: normal protection
// - Status write is 01h plus one byte
// - Read is 03h, 24-bit address, MSB first
// - Address bits 23..18 are ignored
// - Input ignored after full read address
// - Read address increments, wraps to zero
// - Write without latch ignored until deselect
// - Byte write 02h, address, data; programs on deselect
// - Page write wraps low address byte in row
// - Four bytes plus six check bits, corrected reads
// - Every write rewrites whole 4-byte word
// - Status bit 0 shows write in progress
// - 06h sets latch on deselect; zero at power-up
// - 04h clears latch regardless of pin
// - Status read repeats every eight clocks
// - Status bits 6..4 mirror busy
`timescale 1ns/1ps
module spi_eeprom_core #(
  parameter int unsigned WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // Serial pins from the master
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  input wire logic wp_n_i,
  // Serial data out with its enable
  output logic so_o,
  output logic so_oe_o
);
  logic [1:0] rst_q;
  logic rst_n;
  eeprom_pkg::pins_t pins_raw;
  eeprom_pkg::pins_t pin_q1;
  eeprom_pkg::pins_t pin_q2;
  eeprom_pkg::pins_t pin_q3;
  eeprom_pkg::spi_state_t state;
  logic [7:0] cmd;
  logic [6:0] rx_shift;
  logic [2:0] bit_cnt;
  logic [1:0] addr_cnt;
  logic [17:0] addr;
  logic [7:0] status_snap;
  logic pend_set_write_latch_cmd;
  logic pend_clear_write_latch_cmd;
  logic pend_status_write_cmd;
  logic [2:0] status_write_cmd_data;
  logic write_enable_latch;
  logic busy;
  logic status_write_cmd_cycle;
  logic prog_array;
  logic [5:0] prog_idx;
  eeprom_pkg::busy_cnt_t busy_cnt;
  logic [2:0] nv_bits = eeprom_pkg::NV_FACTORY;
  logic [7:0] page_buf [eeprom_pkg::ROW_WORDS][4];
  logic [63:0][3:0] page_mask;
  logic [37:0] mem [eeprom_pkg::WORDS];
  logic [3:0][7:0] rd_data;
  logic [3:0][7:0] merged;
  logic [5:0] wr_check;
  logic [7:0] status_byte;
  logic so_q;
  logic so_oe_q;

  // Reset release through two flops
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_q <= 2'h0;
    end else if (ce_i) begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // Pin synchronisers; third stage only for edge finding
  assign pins_raw = '{cs_n: cs_n_i, sck: sck_i, si: si_i, wp_n: wp_n_i};
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_q1 <= eeprom_pkg::PINS_IDLE;
      pin_q2 <= eeprom_pkg::PINS_IDLE;
      pin_q3 <= eeprom_pkg::PINS_IDLE;
    end else if (ce_i) begin
      pin_q1 <= pins_raw;
      pin_q2 <= pin_q1;
      pin_q3 <= pin_q2;
    end
  end

  wire selected = ~pin_q2.cs_n;
  wire cs_rise = pin_q2.cs_n & ~pin_q3.cs_n;
  wire bit_rise = selected & pin_q2.sck & ~pin_q3.sck;
  wire bit_fall = selected & ~pin_q2.sck & pin_q3.sck;
  wire [7:0] rx_byte = {rx_shift, pin_q2.si};
  wire byte_done = bit_rise & (bit_cnt == 3'h7);
  wire [17:0] next_addr = {addr[9:0], rx_byte};
  wire hw_lock = nv_bits[2] & ~pin_q2.wp_n;
  wire status_wr_ok = write_enable_latch & ~hw_lock;
  wire addr_last = (state == eeprom_pkg::ST_ADDR) && (addr_cnt == eeprom_pkg::ADDR_LAST_BYTE);
  wire write_locked = eeprom_pkg::array_locked(nv_bits[1:0], next_addr);
  wire page_we = byte_done && (state == eeprom_pkg::ST_DATA) && (cmd == eeprom_pkg::OP_WRITE);
  wire mask_clr = byte_done && addr_last;
  wire start_array = cs_rise && (state == eeprom_pkg::ST_DATA) &&
    (cmd == eeprom_pkg::OP_WRITE) && (bit_cnt == 3'h0) && (|page_mask);
  wire start_status = cs_rise && pend_status_write_cmd && (bit_cnt == 3'h0);
  wire busy_end = busy && (busy_cnt == eeprom_pkg::busy_cnt_t'(1));
  wire [15:0] word_idx = busy ? {addr[17:8], prog_idx} : addr[17:2];
  wire mem_we = prog_array && (|page_mask[prog_idx]);
  wire [7:0] out_byte = (state == eeprom_pkg::ST_STATUS) ? status_snap : rd_data[addr[1:0]];

  // Status byte: guard enable, busy mirror, block guard, latch, busy
  always_comb begin
    status_byte = 8'h00;
    status_byte[eeprom_pkg::STAT_GUARD_BIT] = nv_bits[2];
    status_byte[eeprom_pkg::STAT_RSV_MSB:eeprom_pkg::STAT_RSV_LSB] =
      busy ? eeprom_pkg::RSV_BUSY : eeprom_pkg::RSV_IDLE;
    status_byte[eeprom_pkg::STAT_BP_MSB:eeprom_pkg::STAT_BP_LSB] = nv_bits[1:0];
    status_byte[eeprom_pkg::STAT_LATCH_BIT] = write_enable_latch;
    status_byte[eeprom_pkg::STAT_BUSY_BIT] = busy;
  end

  // Error correction on the word being read or merged
  ecc_hamming u_ecc (
    .wr_data_i(merged),
    .wr_check_o(wr_check),
    .rd_word_i(mem[word_idx]),
    .rd_data_o(rd_data)
  );

  // Merge new page bytes into the old word, so the whole word is rewritten
  for (genvar k = 0; k < 4; k++) begin : g_merge
    assign merged[k] = page_mask[prog_idx][k] ? page_buf[prog_idx][k] : rd_data[k];
  end

  // Bit counting; serial input taken on rising edges
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt <= 3'h0;
      rx_shift <= 7'h00;
    end else if (ce_i) begin
      if (!selected) begin
        bit_cnt <= 3'h0;
      end else if (bit_rise) begin
        bit_cnt <= bit_cnt + 3'h1;
        rx_shift <= rx_byte[6:0];
      end
    end
  end

  // Command sequencer
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= eeprom_pkg::ST_OPCODE;
      cmd <= 8'h00;
      addr_cnt <= 2'h0;
      addr <= 18'h00000;
      status_snap <= 8'h00;
      pend_set_write_latch_cmd <= 1'b0;
      pend_clear_write_latch_cmd <= 1'b0;
      pend_status_write_cmd <= 1'b0;
      status_write_cmd_data <= 3'h0;
    end else if (ce_i) begin
      if (cs_rise) begin
        state <= eeprom_pkg::ST_OPCODE;
        addr_cnt <= 2'h0;
        pend_set_write_latch_cmd <= 1'b0;
        pend_clear_write_latch_cmd <= 1'b0;
        pend_status_write_cmd <= 1'b0;
      end else if (byte_done) begin
        case (state)
          eeprom_pkg::ST_OPCODE: begin
            cmd <= rx_byte;
            status_snap <= status_byte;
            if (busy && rx_byte != eeprom_pkg::OP_STATUS_READ) begin
              state <= eeprom_pkg::ST_IGNORE;
            end else begin
              case (rx_byte)
                eeprom_pkg::OP_STATUS_READ: state <= eeprom_pkg::ST_STATUS;
                eeprom_pkg::OP_SET_LATCH: begin
                  pend_set_write_latch_cmd <= 1'b1;
                  state <= eeprom_pkg::ST_IGNORE;
                end
                eeprom_pkg::OP_CLEAR_LATCH: begin
                  pend_clear_write_latch_cmd <= 1'b1;
                  state <= eeprom_pkg::ST_IGNORE;
                end
                eeprom_pkg::OP_STATUS_WRITE: begin
                  state <= status_wr_ok ? eeprom_pkg::ST_DATA : eeprom_pkg::ST_IGNORE;
                end
                eeprom_pkg::OP_READ: state <= eeprom_pkg::ST_ADDR;
                eeprom_pkg::OP_WRITE: begin
                  state <= write_enable_latch ? eeprom_pkg::ST_ADDR : eeprom_pkg::ST_IGNORE;
                end
                default: state <= eeprom_pkg::ST_IGNORE;
              endcase
            end
          end
          eeprom_pkg::ST_ADDR: begin
            addr <= next_addr;
            addr_cnt <= addr_cnt + 2'h1;
            if (addr_last) begin
              if (cmd == eeprom_pkg::OP_READ) begin
                state <= eeprom_pkg::ST_READ;
              end else if (write_locked) begin
                state <= eeprom_pkg::ST_IGNORE;
              end else begin
                state <= eeprom_pkg::ST_DATA;
              end
            end
          end
          eeprom_pkg::ST_DATA: begin
            if (cmd == eeprom_pkg::OP_STATUS_WRITE) begin
              status_write_cmd_data <= {rx_byte[eeprom_pkg::STAT_GUARD_BIT],
                rx_byte[eeprom_pkg::STAT_BP_MSB:eeprom_pkg::STAT_BP_LSB]};
              pend_status_write_cmd <= 1'b1;
              state <= eeprom_pkg::ST_IGNORE;
            end else begin
              addr[7:0] <= addr[7:0] + 8'h01;
            end
          end
          eeprom_pkg::ST_READ: addr <= addr + 18'h00001;
          eeprom_pkg::ST_STATUS: status_snap <= status_byte;
          default: state <= eeprom_pkg::ST_IGNORE;
        endcase
      end
    end
  end

  // Page buffer: data only, validity held in the mask
  always_ff @(posedge clk_i) begin
    if (ce_i && page_we) begin
      page_buf[addr[7:2]][addr[1:0]] <= rx_byte;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      page_mask <= '0;
    end else if (ce_i) begin
      if (mask_clr) begin
        page_mask <= '0;
      end else if (page_we) begin
        page_mask[addr[7:2]][addr[1:0]] <= 1'b1;
      end
    end
  end

  // Self-timed write cycle and write enable latch
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      write_enable_latch <= 1'b0;
      busy <= 1'b0;
      busy_cnt <= '0;
      status_write_cmd_cycle <= 1'b0;
      prog_array <= 1'b0;
      prog_idx <= 6'h00;
    end else if (ce_i) begin
      if (busy) begin
        busy_cnt <= busy_cnt - eeprom_pkg::busy_cnt_t'(1);
        if (prog_array) begin
          prog_idx <= prog_idx + 6'h01;
          prog_array <= (prog_idx != 6'h3F);
        end
        if (busy_end) begin
          busy <= 1'b0;
          write_enable_latch <= 1'b0;
          status_write_cmd_cycle <= 1'b0;
        end
      end else if (start_array || start_status) begin
        busy <= 1'b1;
        busy_cnt <= eeprom_pkg::busy_cnt_t'(WRITE_CYCLES);
        status_write_cmd_cycle <= start_status;
        prog_array <= start_array;
        prog_idx <= 6'h00;
      end else if (cs_rise && pend_set_write_latch_cmd) begin
        write_enable_latch <= 1'b1;
      end else if (cs_rise && pend_clear_write_latch_cmd) begin
        write_enable_latch <= 1'b0;
      end
    end
  end

  // Guard bits hold across resets, like array cells
  always_ff @(posedge clk_i) begin
    if (ce_i && busy_end && status_write_cmd_cycle) begin
      nv_bits <= status_write_cmd_data;
    end
  end

  // Array cells: whole 38-bit word per write
  always_ff @(posedge clk_i) begin
    if (ce_i && mem_we) begin
      mem[word_idx] <= {wr_check, merged};
    end
  end

  // Serial output changes on falling edges
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
    end else if (ce_i) begin
      so_oe_q <= selected &&
        (state == eeprom_pkg::ST_READ || state == eeprom_pkg::ST_STATUS);
      if (bit_fall) begin
        so_q <= out_byte[~bit_cnt];
      end
    end
  end
  assign so_o = so_q;
  assign so_oe_o = so_oe_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n);

  sequence s_opcode(logic [7:0] op);
    ce_i && byte_done && (state == eeprom_pkg::ST_OPCODE) && (rx_byte == op);
  endsequence

  property p_busy_only_status;
    ce_i && byte_done && (state == eeprom_pkg::ST_OPCODE) && busy &&
      (rx_byte != eeprom_pkg::OP_STATUS_READ) |=> (state == eeprom_pkg::ST_IGNORE);
  endproperty
  a_busy_only_status: assert property (p_busy_only_status)
    else $error("command obeyed while busy");

  property p_end_clears_latch;
    ce_i && busy_end |=> !write_enable_latch && !busy ##1 !busy;
  endproperty
  a_end_clears_latch: assert property (p_end_clears_latch)
    else $error("latch or busy left set after write cycle");

  property p_write_needs_latch;
    s_opcode(eeprom_pkg::OP_WRITE) ##0 !write_enable_latch |=> (state == eeprom_pkg::ST_IGNORE);
  endproperty
  a_write_needs_latch: assert property (p_write_needs_latch)
    else $error("array write accepted without latch");

  property p_status_refused;
    s_opcode(eeprom_pkg::OP_STATUS_WRITE) ##0 (!write_enable_latch || hw_lock)
      |=> (state == eeprom_pkg::ST_IGNORE);
  endproperty
  a_status_refused: assert property (p_status_refused)
    else $error("status write accepted while locked");

  property p_guard_bits_change;
    $changed(nv_bits) |-> $past(busy_end) && $past(status_write_cmd_cycle);
  endproperty
  a_guard_bits_change: assert property (p_guard_bits_change)
    else $error("guard bits changed outside status write cycle");

  property p_busy_mirror;
    busy |-> (status_byte[6:4] == 3'h7) && status_byte[0];
  endproperty
  a_busy_mirror: assert property (p_busy_mirror)
    else $error("status does not show busy");

  property p_read_advance;
    ce_i && byte_done && (state == eeprom_pkg::ST_READ) |=> (addr == $past(addr) + 18'h00001);
  endproperty
  a_read_advance: assert property (p_read_advance)
    else $error("read address did not advance");

  property p_page_row;
    ce_i && page_we |=> (addr[17:8] == $past(addr[17:8])) &&
      (addr[7:0] == $past(addr[7:0]) + 8'h01);
  endproperty
  a_page_row: assert property (p_page_row)
    else $error("page address left its row");

  property p_locked_no_cycle;
    ce_i && byte_done && addr_last && (cmd == eeprom_pkg::OP_WRITE) && write_locked
      |=> (state == eeprom_pkg::ST_IGNORE) && (page_mask == '0);
  endproperty
  a_locked_no_cycle: assert property (p_locked_no_cycle)
    else $error("protected address accepted for write");

  property p_idle_floats;
    pin_q2.cs_n |=> !so_oe_o;
  endproperty
  a_idle_floats: assert property (p_idle_floats)
    else $error("output driven while deselected");

  property p_latch_set;
    ce_i && cs_rise && pend_set_write_latch_cmd && !busy |=> write_enable_latch;
  endproperty
  a_latch_set: assert property (p_latch_set)
    else $error("latch not set after enable command");
endmodule // spi_eeprom_core

// File: dv/spi_master_model.sv
// SPI mode 0 master model that drives the EEPROM pins
`timescale 1ns/1ps
module spi_master_model (
  // Clock
  input wire logic clk_i,
  // Serial pins
  output logic cs_n_o,
  output logic sck_o,
  output logic si_o,
  input wire logic so_i,
  input wire logic so_oe_i
);
  logic tog = 1'b0;
  logic so_w;
  // A released data line shows a level that changes every cycle
  assign so_w = so_oe_i ? so_i : tog;
  always @(posedge clk_i) tog <= ~tog;
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
  end
  task automatic open_f();
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  // Each sck half period is 4 clocks; data is taken late in the high phase
  task automatic xb(input logic [7:0] o, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      si_o <= o[i];
      repeat (4) @(posedge clk_i);
      sck_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      r[i] = so_w;
      sck_o <= 1'b0;
    end
  endtask
  task automatic close_f();
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
endmodule // spi_master_model

// File: dv/spi_eeprom_protect_read_write_tb.sv
// Self-checking bench for the SPI EEPROM core
`timescale 1ns/1ps
module spi_eeprom_protect_read_write_tb;
  localparam int unsigned WC = 300;
  localparam logic [17:0] AB [4] = '{18'h1FFFC, 18'h20000, 18'h2FFFC, 18'h30000};
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic wp_n_i = 1'b1;
  logic cs_n, sck, si, so_o, so_oe_o;
  int err_total = 0;
  int n_compared = 0;
  logic [31:0] seed = 32'hD3DC;
  logic [7:0] st, r;
  logic [7:0] d[$];
  logic [7:0] e[$];
  logic [7:0] f[$];
  logic [7:0] q[$];
  logic [23:0] a;

  initial forever #50 clk_i = ~clk_i;

  spi_eeprom_core #(.WRITE_CYCLES(WC)) dut (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1),
    .cs_n_i(cs_n), .sck_i(sck), .si_i(si), .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_o(so_oe_o));
  spi_master_model m (.clk_i(clk_i), .cs_n_o(cs_n), .sck_o(sck), .si_o(si), .so_i(so_o),
    .so_oe_i(so_oe_o));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] sv(logic gd, logic [1:0] bp, logic wl, logic bz);
    return {gd, {3{bz}}, bp, wl, bz};
  endfunction
  function automatic logic lk(logic [1:0] bp, logic [17:0] ad);
    return bp == 2'h3 || (bp == 2'h2 && ad >= 18'h20000) || (bp == 2'h1 && ad >= 18'h30000);
  endfunction
  task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Sends q, then clocks nr more random bytes and keeps what comes back in e
  task automatic frm(input int nr);
    m.open_f();
    foreach (q[i]) m.xb(q[i], r);
    e = {};
    repeat (nr) begin
      m.xb(8'(xs()), r);
      e.push_back(r);
    end
    m.close_f();
    check("so_oe idle", {7'h0, so_oe_o}, 8'h00);
  endtask
  task automatic cmd(input logic [7:0] op);
    q = {op};
    frm(0);
  endtask
  task automatic stat();
    q = {8'h05};
    frm(1);
    st = e[0];
  endtask
  task automatic rnd(input int n);
    d = {};
    repeat (n) d.push_back(8'(xs()));
  endtask
  task automatic wr(input logic [23:0] ad);
    cmd(8'h06);
    q = {8'h02, ad[23:16], ad[15:8], ad[7:0]};
    q = {q, d};
    frm(0);
  endtask
  task automatic swr(input logic [7:0] v);
    cmd(8'h06);
    q = {8'h01, v};
    frm(0);
  endtask
  task automatic rd(input logic [23:0] ad, input int n);
    q = {8'h03, ad[23:16], ad[15:8], ad[7:0]};
    frm(n);
  endtask
  task automatic poll(input logic [7:0] exp);
    m.open_f();
    // Status read opcode first, then the snapshot is refreshed every byte
    m.xb(8'h05, r);
    for (int k = 0; k < 40; k++) begin
      m.xb(8'h00, r);
      if (r[0] === 1'b0) break;
    end
    m.close_f();
    check("status after cycle", r, exp);
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    stat();
    check("status at power-up", st, 8'h00);
    cmd(8'h06);
    stat();
    check("latch set", st, 8'h02);
    cmd(8'h04);
    stat();
    check("latch cleared", st, 8'h00);
    rnd(4);
    q = {8'h02, 8'h00, 8'h00, 8'h00, d};
    frm(0);
    stat();
    check("write without latch", st, 8'h00);
    // Page write crossing the row end
    a = 24'(xs());
    a[7:0] = 8'hFC;
    rnd(8);
    wr(a);
    stat();
    check("busy status", st, 8'h73);
    cmd(8'h06);
    poll(8'h00);
    rd({a[23:8], 8'h00} ^ 24'hFC0000, 4);
    for (int i = 0; i < 4; i++) check("row start", e[i], d[i + 4]);
    rd(a, 4);
    for (int i = 0; i < 4; i++) check("row end", e[i], d[i]);
    // Read running past the top address
    rnd(4);
    wr(24'h03FFFC);
    poll(8'h00);
    f = d;
    rnd(4);
    wr(24'h000000);
    poll(8'h00);
    rd(24'h03FFFE, 4);
    for (int i = 0; i < 4; i++) check("read wrap", e[i], i < 2 ? f[i + 2] : d[i - 2]);
    // Every block guard code against region boundaries
    for (int bp = 0; bp < 4; bp++) begin
      r = 8'(xs());
      swr({1'b0, r[6:4], 2'(bp), r[1:0]});
      poll(sv(1'b0, 2'(bp), 1'b0, 1'b0));
      for (int k = 0; k < 4; k++) begin
        a = {6'(xs()), AB[k]};
        rnd(4);
        wr(a);
        stat();
        check("guarded write", st, sv(1'b0, 2'(bp), 1'b1, !lk(2'(bp), a[17:0])));
        poll(sv(1'b0, 2'(bp), lk(2'(bp), a[17:0]), 1'b0));
      end
    end
    swr(8'h84);
    poll(8'h84);
    wp_n_i <= 1'b0;
    swr(8'h00);
    stat();
    check("status locked by pin", st, 8'h86);
    rnd(4);
    wr(24'h000000);
    stat();
    check("open block under pin", st, 8'hF7);
    poll(8'h84);
    rstn_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    stat();
    check("guard kept over reset", st, 8'h84);
    cmd(8'h06);
    cmd(8'h04);
    stat();
    check("clear latch under pin", st, 8'h84);
    wp_n_i <= 1'b1;
    swr(8'h00);
    poll(8'h00);
    wrap_up();
  end

  initial begin
    repeat (90000) @(posedge clk_i);
    err_total++;
    wrap_up();
  end
endmodule // spi_eeprom_protect_read_write_tb
